// *** logic/hmap_consts.svh ***
// Constants for the host memory access port.
// Notes on behaviour
// - Thirty-four registers, each sixteen bits, always moved as whole words.
// - On-chip memories are word-only; local DRAM accepts byte or word access.
// - Byte address 2x is high byte of word x; 2x+1 low byte.
// - Upper and lower byte strobes select lanes and tell bytes from words.
// - Host bitstream words are held in a sixteen-entry coded-data FIFO.
// - DRAM controller drains the FIFO into the bitstream buffer in DRAM.
// - DRAM holds 256K or 512K words; addresses up to 0x3FFFF or 0x7FFFF.
// - Each memory is addressed in units of its own word size.
`ifndef HMAP_CONSTS_SVH
`define HMAP_CONSTS_SVH
`define HMAP_NUM_REGS      6'h22
`define HMAP_DATA_W        16
`define HMAP_FIFO_DEPTH    16
`define HMAP_DRAM_MAX_256K 19'h3FFFF
`define HMAP_DRAM_MAX_512K 19'h7FFFF
`define HMAP_BBUF_BASE     19'h00000
`define HMAP_BBUF_LAST     19'h0FFFF
`define HMAP_UNIT_REG      16
`define HMAP_UNIT_DRAM     16
`define HMAP_UNIT_HSM      16
`define HMAP_UNIT_CDF      16
`define HMAP_UNIT_IM       32
`define HMAP_UNIT_TM       24
`endif

// *** logic/hmap_fifo.sv ***
// Parameterised valid/ready FIFO in flip-flops.
`timescale 1ns/1ps
module hmap_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and control
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic             clk_en,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   // Status
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("hmap_fifo: DEPTH must be a power of two of at least 2");
      end
   end
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      cnt_ff;
   wire              do_wr = in_valid && in_ready;
   wire              do_rd = out_valid && out_ready;
   // Ready drops at a full count, so the source is held off until a word leaves.
   assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem_ff[rd_ptr_ff];
   assign level     = cnt_ff;
   always_ff @(posedge mclk) begin
      if (clk_en && do_wr) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff    <= '0;
      end else if (clk_en) begin
         if (do_wr) wr_ptr_ff <= wr_ptr_ff + 1'b1;
         if (do_rd) rd_ptr_ff <= rd_ptr_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule : hmap_fifo

// *** logic/hmap_lane.sv ***
// Byte lane decoder for host DRAM accesses.
`timescale 1ns/1ps
module hmap_lane
   import hmap_pkg::*;
(
   // Host strobes and data
   input  wire logic        upper_byte_strobe,
   input  wire logic        lower_byte_strobe,
   input  wire logic [15:0] host_wdata,
   // Decoded lanes
   output hmap_lane_t       lane,
   output logic [1:0]       lane_en,
   output logic [15:0]      lane_wdata
);
   // Upper strobe is the even byte 2x, bits 15:8; lower is 2x+1, bits 7:0.
   assign lane_en    = {upper_byte_strobe, lower_byte_strobe};
   assign lane       = (upper_byte_strobe && lower_byte_strobe) ? HMAP_LANE_WORD :
                       upper_byte_strobe ? HMAP_LANE_HI :
                       lower_byte_strobe ? HMAP_LANE_LO : HMAP_LANE_NONE;
   assign lane_wdata = host_wdata;
endmodule : hmap_lane

// *** logic/hmap_pkg.sv ***
// Types shared by the host memory access port.
package hmap_pkg;
   typedef enum logic [1:0] {HMAP_TGT_REG, HMAP_TGT_DRAM, HMAP_TGT_CDF} hmap_tgt_t;
   typedef enum logic [1:0] {HMAP_LANE_NONE, HMAP_LANE_HI, HMAP_LANE_LO, HMAP_LANE_WORD}
      hmap_lane_t;
   typedef struct packed {
      logic [18:0] addr;
      logic [15:0] wdata;
      logic [1:0]  lane_en;
      logic        we;
   } hmap_dram_req_t;
   typedef struct packed {
      logic [5:0]  idx;
      logic [15:0] wdata;
      logic        we;
   } hmap_reg_req_t;
endpackage : hmap_pkg

// *** logic/hmap_port.sv ***
// Host memory access port: registers, DRAM byte/word path and coded-data FIFO.
`timescale 1ns/1ps
`include "hmap_consts.svh"
module hmap_port
   import hmap_pkg::*;
#(
   parameter int  FIFO_DEPTH = `HMAP_FIFO_DEPTH,
   parameter bit  DRAM_512K  = 1'b1
) (
   // Clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   // Host request
   input  wire logic        host_req,
   input  wire logic        host_we,
   input  wire hmap_tgt_t   host_tgt,
   input  wire logic [18:0] host_addr,
   input  wire logic [15:0] host_wdata,
   input  wire logic        upper_byte_strobe,
   input  wire logic        lower_byte_strobe,
   // Host answer
   output logic             host_ack_ff,
   output logic             host_err_ff,
   output logic [15:0]      host_rdata_ff,
   output logic             cdf_full_ff,
   output logic [4:0]       cdf_level_ff,
   // Register file access
   output hmap_reg_req_t    reg_req_ff,
   output logic             reg_req_valid_ff,
   input  wire logic [15:0] reg_rdata,
   // DRAM controller side
   output hmap_dram_req_t   dram_req_ff,
   output logic             dram_req_valid_ff,
   input  wire logic        dram_ack,
   input  wire logic [15:0] dram_rdata
);
   initial begin
      if (FIFO_DEPTH != `HMAP_FIFO_DEPTH) begin
         $error("hmap_port: FIFO depth must be sixteen words");
      end
   end
   typedef enum logic [2:0] {ST_IDLE, ST_REG, ST_DRAM, ST_ANS} st_t;
   st_t              st_ff;
   st_t              nxt_st;
   logic [18:0]      bbuf_ptr_ff;
   logic             drain_busy_ff;
   hmap_lane_t       lane;
   logic [1:0]       lane_en;
   logic [15:0]      lane_wdata;
   logic             cdf_in_ready;
   logic             cdf_out_valid;
   logic [15:0]      cdf_out_data;
   logic [4:0]       cdf_level;
   logic [15:0]      ans_data_ff;
   logic             ans_err_ff;

   function automatic logic dram_addr_ok(input logic [18:0] a);
      dram_addr_ok = DRAM_512K ? (a <= `HMAP_DRAM_MAX_512K) : (a <= `HMAP_DRAM_MAX_256K);
   endfunction : dram_addr_ok

   hmap_lane u_lane (
      .upper_byte_strobe (upper_byte_strobe),
      .lower_byte_strobe (lower_byte_strobe),
      .host_wdata        (host_wdata),
      .lane              (lane),
      .lane_en           (lane_en),
      .lane_wdata        (lane_wdata)
   );

   // Request decode.
   wire in_idle    = (st_ff == ST_IDLE);
   wire is_reg     = host_tgt == HMAP_TGT_REG;
   wire is_dram    = host_tgt == HMAP_TGT_DRAM;
   wire is_cdf     = host_tgt == HMAP_TGT_CDF;
   // Registers and on-chip memories take whole words only.
   wire reg_ok     = (host_addr < 19'(`HMAP_NUM_REGS)) && (lane == HMAP_LANE_WORD);
   wire dram_ok    = dram_addr_ok(host_addr) && (lane != HMAP_LANE_NONE);
   wire cdf_ok     = (lane == HMAP_LANE_WORD) && host_we;
   // No take while the answer still shows: the host drops its request on that same edge.
   wire can_take   = in_idle && !host_ack_ff;
   wire cdf_push   = can_take && host_req && is_cdf && cdf_ok && cdf_in_ready;
   // A host DRAM access waits for a pending drain write, so it can never overwrite it.
   wire host_take  = can_take && host_req && !(is_cdf && cdf_ok && !cdf_in_ready) &&
                     !(is_dram && dram_req_valid_ff);
   wire bad_req    = (is_reg && !reg_ok) || (is_dram && !dram_ok) || (is_cdf && !cdf_ok) ||
                     (host_tgt == hmap_tgt_t'(2'h3));
   // Host requests win the DRAM port; the drain waits for idle host cycles.
   wire drain_go   = cdf_out_valid && !drain_busy_ff && in_idle &&
                     !(host_req && is_dram) && !dram_req_valid_ff;
   wire drain_pop  = drain_busy_ff && dram_ack;
   wire [18:0] bbuf_nxt = (bbuf_ptr_ff == `HMAP_BBUF_LAST) ? `HMAP_BBUF_BASE :
                          bbuf_ptr_ff + 19'h00001;

   hmap_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_cdf (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .in_valid  (cdf_push),
      .in_ready  (cdf_in_ready),
      .in_data   (lane_wdata),
      .out_valid (cdf_out_valid),
      .out_ready (drain_pop),
      .out_data  (cdf_out_data),
      .level     (cdf_level)
   );

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE: begin
            if (host_take) begin
               if (bad_req || is_cdf) nxt_st = ST_ANS;
               else if (is_reg) nxt_st = ST_REG;
               else nxt_st = ST_DRAM;
            end
         end
         ST_REG:  nxt_st = ST_ANS;
         ST_DRAM: if (dram_ack && !drain_busy_ff) nxt_st = ST_ANS;
         ST_ANS:  nxt_st = ST_IDLE;
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) st_ff <= ST_IDLE;
      else if (clk_en) st_ff <= nxt_st;
   end

   // Register path: one word per access, index in 16-bit units.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_req_ff       <= '0;
         reg_req_valid_ff <= 1'b0;
      end else if (clk_en) begin
         reg_req_valid_ff <= host_take && !bad_req && is_reg;
         reg_req_ff       <= '{idx: host_addr[5:0], wdata: host_wdata, we: host_we};
      end
   end

   // DRAM port shared by host accesses and the bitstream drain.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dram_req_ff       <= '0;
         dram_req_valid_ff <= 1'b0;
         drain_busy_ff     <= 1'b0;
         bbuf_ptr_ff       <= `HMAP_BBUF_BASE;
      end else if (clk_en) begin
         if (dram_req_valid_ff && dram_ack) begin
            dram_req_valid_ff <= 1'b0;
            drain_busy_ff     <= 1'b0;
         end
         if (drain_pop) bbuf_ptr_ff <= bbuf_nxt;
         if (host_take && !bad_req && is_dram) begin
            dram_req_valid_ff <= 1'b1;
            dram_req_ff       <= '{addr: host_addr, wdata: lane_wdata, lane_en: lane_en,
                                   we: host_we};
         end else if (drain_go) begin
            dram_req_valid_ff <= 1'b1;
            drain_busy_ff     <= 1'b1;
            dram_req_ff       <= '{addr: bbuf_ptr_ff, wdata: cdf_out_data, lane_en: 2'h3,
                                   we: 1'b1};
         end
      end
   end

   // Answer capture. Unused byte lanes of a DRAM read return zero.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ans_data_ff <= 16'h0000;
         ans_err_ff  <= 1'b0;
      end else if (clk_en) begin
         if (in_idle && host_take) begin
            ans_err_ff  <= bad_req;
            ans_data_ff <= 16'h0000;
         end else if (st_ff == ST_REG) begin
            ans_data_ff <= reg_req_ff.we ? 16'h0000 : reg_rdata;
         end else if (st_ff == ST_DRAM && dram_ack && !drain_busy_ff) begin
            ans_data_ff <= dram_req_ff.we ? 16'h0000 :
                           {dram_req_ff.lane_en[1] ? dram_rdata[15:8] : 8'h00,
                            dram_req_ff.lane_en[0] ? dram_rdata[7:0]  : 8'h00};
         end
      end
   end

   // Outputs.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         host_ack_ff   <= 1'b0;
         host_err_ff   <= 1'b0;
         host_rdata_ff <= 16'h0000;
         cdf_full_ff   <= 1'b0;
         cdf_level_ff  <= 5'h00;
      end else if (clk_en) begin
         host_ack_ff   <= (st_ff == ST_ANS);
         host_err_ff   <= (st_ff == ST_ANS) && ans_err_ff;
         host_rdata_ff <= (st_ff == ST_ANS) ? ans_data_ff : 16'h0000;
         cdf_full_ff   <= !cdf_in_ready;
         cdf_level_ff  <= cdf_level;
      end
   end
endmodule : hmap_port

// *** test/hmap_dram_model.sv ***
// Behavioural local DRAM controller answering the port's requests.
`timescale 1ns/1ps
module hmap_dram_model
   import hmap_pkg::*;
(
   input  wire logic           mclk,
   input  wire logic           rst_n,
   input  wire hmap_dram_req_t dram_req_ff,
   input  wire logic           dram_req_valid_ff,
   output logic                dram_ack = 1'b0,
   output logic [15:0]         dram_rdata = 16'h5A5A
);
   logic [15:0] mem [int];
   logic [15:0] old_w;
   int          delay = 0;
   int          wait_cnt = 0;
   always @(posedge mclk) begin
      dram_ack <= 1'b0;
      // Idle data toggles each cycle, so a stale word shows again only on every second cycle.
      dram_rdata <= ~dram_rdata;
      if (!rst_n) begin
         wait_cnt <= 0;
      end else if (dram_req_valid_ff && !dram_ack) begin
         wait_cnt <= wait_cnt + 1;
         if (wait_cnt >= delay) begin
            wait_cnt <= 0;
            dram_ack <= 1'b1;
            old_w = mem.exists(dram_req_ff.addr) ? mem[dram_req_ff.addr] : 16'h0000;
            if (dram_req_ff.we) begin
               mem[dram_req_ff.addr] = {dram_req_ff.lane_en[1] ? dram_req_ff.wdata[15:8]
                  : old_w[15:8], dram_req_ff.lane_en[0] ? dram_req_ff.wdata[7:0] : old_w[7:0]};
            end else begin
               dram_rdata <= old_w;
            end
         end
      end
   end
endmodule : hmap_dram_model

// *** test/hmap_port_asserts.sv ***
// Concurrent checks on the host memory access port.
`timescale 1ns/1ps
module hmap_port_chk
   import hmap_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter bit DRAM_512K  = 1'b1
) (
   // Clock and reset
   input wire logic           mclk, rst_n,
   // Host answer
   input wire logic           host_ack_ff, host_err_ff, cdf_full_ff,
   input wire logic [15:0]    host_rdata_ff,
   input wire logic [4:0]     cdf_level_ff,
   // Register and DRAM sides
   input wire hmap_reg_req_t  reg_req_ff,
   input wire logic           reg_req_valid_ff,
   input wire hmap_dram_req_t dram_req_ff,
   input wire logic           dram_req_valid_ff, dram_ack
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [18:0] dram_max;
   assign dram_max = DRAM_512K ? 19'h7FFFF : 19'h3FFFF;
   a_err_with_ack: assert property (host_err_ff |-> host_ack_ff)
      else $error("error flag without answer");
   a_rdata_idle_zero: assert property (!host_ack_ff |-> host_rdata_ff == 16'h0000)
      else $error("read data shown outside answer");
   a_full_flag: assert property (cdf_full_ff == (cdf_level_ff == 5'(FIFO_DEPTH)))
      else $error("full flag disagrees with level");
   a_level_bound: assert property (cdf_level_ff <= $past(cdf_level_ff) + 5'h01
      && cdf_level_ff <= 5'(FIFO_DEPTH))
      else $error("coded FIFO level overshoots");
   a_dram_req_hold: assert property (dram_req_valid_ff && !dram_ack
      |=> dram_req_valid_ff && $stable(dram_req_ff))
      else $error("DRAM request dropped before acknowledge");
   a_dram_lanes_set: assert property (dram_req_valid_ff |-> dram_req_ff.lane_en != 2'h0)
      else $error("DRAM request with no lane");
   a_dram_addr_max: assert property (dram_req_valid_ff |-> dram_req_ff.addr <= dram_max)
      else $error("DRAM address beyond memory size");
   a_reg_idx_range: assert property (reg_req_valid_ff |-> reg_req_ff.idx < 6'h22)
      else $error("register index out of range");
   a_reg_answer: assert property (reg_req_valid_ff |-> ##[1:2] host_ack_ff)
      else $error("register access not answered");
   c_full: cover property (cdf_full_ff);
   c_err: cover property (host_err_ff);
   c_reg: cover property (reg_req_valid_ff);
endmodule : hmap_port_chk

bind hmap_port hmap_port_chk #(.FIFO_DEPTH(FIFO_DEPTH), .DRAM_512K(DRAM_512K)) u_chk (
   .mclk(mclk), .rst_n(rst_n), .host_ack_ff(host_ack_ff), .host_err_ff(host_err_ff),
   .cdf_full_ff(cdf_full_ff), .host_rdata_ff(host_rdata_ff), .cdf_level_ff(cdf_level_ff),
   .reg_req_ff(reg_req_ff), .reg_req_valid_ff(reg_req_valid_ff), .dram_req_ff(dram_req_ff),
   .dram_req_valid_ff(dram_req_valid_ff), .dram_ack(dram_ack));

// *** test/hmap_port_test.sv ***
// Self-checking bench for the host memory access port.
`timescale 1ns/1ps
module hmap_port_test
   import hmap_pkg::*;
;
   logic mclk, rst_n, host_req, host_we, ubs, lbs, acked, got_e;
   logic mclk_en = 1'b1;
   hmap_tgt_t host_tgt;
   logic [18:0] host_addr;
   logic [15:0] host_wdata, reg_rdata, got_d, host_rdata_ff, dram_rdata;
   logic host_ack_ff, host_err_ff, cdf_full_ff, reg_req_valid_ff, dram_req_valid_ff, dram_ack;
   logic [4:0] cdf_level_ff;
   hmap_reg_req_t reg_req_ff, seen_reg;
   hmap_dram_req_t dram_req_ff;
   int failures = 0;
   int checks_done = 0;
   int n;
   hmap_port #(.DRAM_512K(1'b0)) uut (.mclk(mclk), .rst_n(rst_n), .clk_en(mclk_en),
      .host_req(host_req), .host_we(host_we), .host_tgt(host_tgt), .host_addr(host_addr),
      .host_wdata(host_wdata), .upper_byte_strobe(ubs), .lower_byte_strobe(lbs),
      .host_ack_ff(host_ack_ff), .host_err_ff(host_err_ff), .host_rdata_ff(host_rdata_ff),
      .cdf_full_ff(cdf_full_ff), .cdf_level_ff(cdf_level_ff), .reg_req_ff(reg_req_ff),
      .reg_req_valid_ff(reg_req_valid_ff), .reg_rdata(reg_rdata), .dram_req_ff(dram_req_ff),
      .dram_req_valid_ff(dram_req_valid_ff), .dram_ack(dram_ack), .dram_rdata(dram_rdata));
   hmap_dram_model u_dram (.mclk(mclk), .rst_n(rst_n), .dram_req_ff(dram_req_ff),
      .dram_req_valid_ff(dram_req_valid_ff), .dram_ack(dram_ack), .dram_rdata(dram_rdata));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Leaves the request up when no answer came, so a stalled write stays pending.
   task automatic wait_ack(input int lim);
      acked = 1'b0;
      for (int i = 0; i < lim && !acked; i++) begin
         @(posedge mclk);
         if (reg_req_valid_ff === 1'b1) seen_reg = reg_req_ff;
         if (host_ack_ff === 1'b1) begin
            acked = 1'b1;
            got_d = host_rdata_ff;
            got_e = host_err_ff;
            host_req <= 1'b0;
         end
      end
   endtask : wait_ack
   task automatic xfer(input hmap_tgt_t tg, input logic we, input logic [18:0] a,
                       input logic [15:0] d, input logic [1:0] st, input int lim);
      @(posedge mclk);
      host_req <= 1'b1;
      host_we <= we;
      host_tgt <= tg;
      host_addr <= a;
      host_wdata <= d;
      {ubs, lbs} <= st;
      wait_ack(lim);
   endtask : xfer
   task automatic t_regs;
      reg_rdata <= 16'hA5C3;
      xfer(HMAP_TGT_REG, 1'b1, 19'h21, 16'h5AA5, 2'b11, 20);
      chk("reg write err", 19'h0, got_e);
      chk("reg index", 19'h21, 19'(seen_reg.idx));
      chk("reg wdata", 19'h5AA5, 19'(seen_reg.wdata));
      xfer(HMAP_TGT_REG, 1'b0, 19'h0, 16'h0, 2'b11, 20);
      chk("reg read", 19'hA5C3, 19'(got_d));
      xfer(HMAP_TGT_REG, 1'b1, 19'h22, 16'h0, 2'b11, 20);
      chk("reg idx 34 err", 19'h1, got_e);
      xfer(HMAP_TGT_REG, 1'b1, 19'h0, 16'h0, 2'b10, 20);
      chk("reg byte err", 19'h1, got_e);
      xfer(HMAP_TGT_REG, 1'b0, 19'h0, 16'h0, 2'b01, 20);
      chk("reg byte rd err", 19'h1, got_e);
      // A low clock enable must freeze the port: no take and no answer until it returns.
      mclk_en <= 1'b0;
      xfer(HMAP_TGT_REG, 1'b0, 19'h1, 16'h0, 2'b11, 8);
      chk("frozen no ack", 19'h0, 19'(acked));
      mclk_en <= 1'b1;
      wait_ack(20);
      chk("thawed read", 19'hA5C3, 19'(got_d));
   endtask : t_regs
   task automatic t_dram;
      u_dram.delay <= 3;
      xfer(HMAP_TGT_DRAM, 1'b1, 19'h3FFFF, 16'h1234, 2'b11, 40);
      chk("dram top err", 19'h0, got_e);
      xfer(HMAP_TGT_DRAM, 1'b1, 19'h3FFFF, 16'hAB99, 2'b10, 40);
      xfer(HMAP_TGT_DRAM, 1'b0, 19'h3FFFF, 16'h0, 2'b11, 40);
      chk("upper byte", 19'hAB34, 19'(got_d));
      xfer(HMAP_TGT_DRAM, 1'b1, 19'h3FFFF, 16'h77CD, 2'b01, 40);
      xfer(HMAP_TGT_DRAM, 1'b0, 19'h3FFFF, 16'h0, 2'b01, 40);
      chk("lower byte read", 19'h00CD, 19'(got_d));
      xfer(HMAP_TGT_DRAM, 1'b0, 19'h3FFFF, 16'h0, 2'b11, 40);
      chk("dram word", 19'hABCD, 19'(got_d));
      xfer(HMAP_TGT_DRAM, 1'b0, 19'h40000, 16'h0, 2'b11, 40);
      chk("dram range err", 19'h1, got_e);
      xfer(HMAP_TGT_DRAM, 1'b1, 19'h0, 16'h0, 2'b00, 40);
      chk("no strobe err", 19'h1, got_e);
   endtask : t_dram
   task automatic t_fifo;
      xfer(HMAP_TGT_CDF, 1'b0, 19'h0, 16'h0, 2'b11, 20);
      chk("fifo read err", 19'h1, got_e);
      xfer(hmap_tgt_t'(2'h3), 1'b1, 19'h0, 16'h0, 2'b11, 20);
      chk("bad target err", 19'h1, got_e);
      u_dram.delay <= 300;
      n = 0;
      while (cdf_full_ff !== 1'b1 && n < 18) begin
         xfer(HMAP_TGT_CDF, 1'b1, 19'h0, 16'hC000 + 16'(n), 2'b11, 20);
         n++;
      end
      chk("fifo level", 19'h10, 19'(cdf_level_ff));
      chk("fifo full", 19'h1, 19'(cdf_full_ff));
      xfer(HMAP_TGT_CDF, 1'b1, 19'h0, 16'hC000 + 16'(n), 2'b11, 10);
      chk("full write held", 19'h0, 19'(acked));
      u_dram.delay <= 0;
      wait_ack(400);
      chk("held write taken", 19'h1, 19'(acked));
      n++;
      for (int i = 0; i < 2000 && (cdf_level_ff !== 5'h00 || dram_req_valid_ff !== 1'b0); i++)
         @(posedge mclk);
      for (int k = 0; k < n; k++)
         chk("buffer word", 19'hC000 + 19'(k), u_dram.mem.exists(k) ? 19'(u_dram.mem[k]) : 'x);
   endtask : t_fifo
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #(50 * 20000);
      failures++;
      give_verdict();
   end
   initial begin
      {rst_n, host_req, host_we, ubs, lbs} = 5'h00;
      host_tgt = HMAP_TGT_REG;
      host_addr = 19'h0;
      host_wdata = 16'h0;
      reg_rdata = 16'h0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs();
      t_dram();
      t_fifo();
      give_verdict();
   end
endmodule : hmap_port_test
